// >>> fic_pkg.sv
// Purpose: Shared constants and types of the flash ISP entry control block
// Assumes: Registers are word indices on AXI4-Lite; byte address is four times the index
// Notes: Instruction cycle is mclk divided by ICYC_DIV
package fic_pkg;
	// ************************************************************
	// Timing and keys
	// ************************************************************
	localparam int unsigned MCLK_HZ = 200000000;
	localparam int unsigned ICYC_DIV = 10;
	localparam logic [3:0] ICYC_LAST = 4'(ICYC_DIV - 1);
	localparam logic [2:0] KEY_WINDOW = 3'h6;
	localparam logic [3:0] KEY_AGE_MAX = 4'hf;
	localparam logic [9:0] WD_SVC_LAST = 10'h1f3;
	localparam logic [7:0] KEY_VALUE = 8'h98;
	localparam logic [7:0] MASS_KEY = 8'h55;
	// ************************************************************
	// Register indices and status bits
	// ************************************************************
	localparam logic [7:0] IDX_ADDR_LO = 8'ha8;
	localparam logic [7:0] IDX_ADDR_HI = 8'ha9;
	localparam logic [7:0] IDX_RD_DATA = 8'haa;
	localparam logic [7:0] IDX_WR_DATA = 8'hab;
	localparam logic [7:0] IDX_TIMING = 8'he1;
	localparam logic [7:0] IDX_UNLOCK = 8'he2;
	localparam logic [7:0] IDX_COUNT = 8'hf1;
	localparam logic [7:0] IDX_STATUS = 8'hc0;
	localparam int unsigned SB_IGNORED = 3;
	localparam int unsigned SB_REFUSED = 4;
	localparam int unsigned SB_MASSKEY = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************************************************
	// Entry points and serial commands
	// ************************************************************
	localparam logic [7:0] EP_PAGE = 8'h17;
	localparam logic [7:0] EP_MASS = 8'h1a;
	localparam logic [7:0] EP_READ = 8'h11;
	localparam logic [7:0] EP_BLK_RD = 8'h26;
	localparam logic [7:0] EP_WRITE = 8'h14;
	localparam logic [7:0] EP_BLK_WR = 8'h23;
	localparam logic [7:0] EP_EXIT = 8'h62;
	localparam logic [7:0] EP_SERIAL = 8'h00;
	localparam logic [7:0] SCMD_WR_TIMING = 8'h70;
	localparam logic [7:0] SCMD_RD_OPTION = 8'h71;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {FL_READ, FL_WRITE, FL_PAGE, FL_MASS} fic_flop_type;
	typedef enum logic [1:0] {FIC_IDLE, FIC_RUN, FIC_SER_IDLE, FIC_SER_RUN} fic_state_type;
	typedef enum logic [1:0] {SQ_IDLE, SQ_LOAD, SQ_WAIT, SQ_STEP} fic_sq_state_type;
	typedef struct packed {
		fic_state_type state;
		logic awready, wready, bvalid, arready, rvalid, aw_got, w_got, wlane;
		logic [1:0] bresp, rresp;
		logic [9:0] awidx, wd_cnt;
		logic [7:0] wbyte, rdata, addr_lo, addr_hi, rd_data, wr_data, timing, key, count;
		logic [7:0] xptr, cmd, irq_lat, irq_pend, ser_rdata;
		logic [3:0] div, key_age;
		logic [2:0] key_cnt;
		logic icyc, key_ok, active, seq_start, irq_block, wdog_service, wdog_lower;
		logic call_done, reset_req, ser_ack, ser_refused, f_ignored, f_refused, f_masskey;
	} fic_top_type;
	typedef struct packed {
		fic_sq_state_type state;
		fic_flop_type op;
		logic done, blk, fl_req, ram_we;
		logic [15:0] fl_addr;
		logic [7:0] fl_wdata, rdata, ram_addr, ram_wdata, left, cnt_lat, acks;
	} fic_seq_type;
	function automatic logic fic_is_op(input logic [7:0] c);
		fic_is_op = (c == EP_READ) || (c == EP_WRITE) || (c == EP_PAGE) || (c == EP_MASS)
			|| (c == EP_BLK_RD) || (c == EP_BLK_WR);
	endfunction
	function automatic logic fic_sec_ok(input logic [7:0] c);
		fic_sec_ok = (c == EP_MASS) || (c == SCMD_WR_TIMING) || (c == SCMD_RD_OPTION);
	endfunction
	function automatic logic fic_hit(input logic [9:0] a, input logic [7:0] idx);
		fic_hit = (a == {2'h0, idx});
	endfunction
endpackage

// >>> fic_sq_if.sv
// Purpose: Carries one flash operation from the entry control to the sequencer
// Assumes: start and done are one-cycle pulses
// Notes: Parameters must be stable while start is high
`timescale 1ns/100ps
interface fic_sq_if;
	logic start;
	logic [7:0] cmd;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] count;
	logic [7:0] xptr;
	logic done;
	logic [7:0] rdata;
	modport ctl (output start, cmd, addr, wdata, count, xptr, input done, rdata);
	modport seq (input start, cmd, addr, wdata, count, xptr, output done, rdata);
endinterface

// >>> fic_seq.sv
// Purpose: Turns one ISP command into flash byte operations and RAM moves
// Assumes: ram_rdata is a combinational read of ram_addr; fl_ack is a one-cycle pulse
// Notes: Block range limits are left to software
`timescale 1ns/100ps
module fic_seq (
	input wire logic mclk,
	input wire logic rst,
	fic_sq_if.seq sq,
	output logic fl_req,
	output logic [1:0] fl_op,
	output logic [15:0] fl_addr,
	output logic [7:0] fl_wdata,
	input wire logic fl_ack,
	input wire logic [7:0] fl_rdata,
	output logic [7:0] ram_addr,
	output logic ram_we,
	output logic [7:0] ram_wdata,
	input wire logic [7:0] ram_rdata
);
	fic_pkg::fic_seq_type st;
	fic_pkg::fic_seq_type nx;

	always_comb
	begin
		nx = st;
		nx.done = 1'h0;
		nx.ram_we = 1'h0;
		case (st.state)
		fic_pkg::SQ_IDLE:
		begin
			if (sq.start)
			begin
				nx.fl_addr = sq.addr; // R3
				nx.ram_addr = sq.xptr;
				nx.fl_wdata = sq.wdata;
				nx.blk = (sq.cmd == fic_pkg::EP_BLK_RD) || (sq.cmd == fic_pkg::EP_BLK_WR);
				nx.left = nx.blk ? sq.count : 8'h01; // R6
				nx.cnt_lat = nx.left;
				nx.acks = 8'h00;
				if ((sq.cmd == fic_pkg::EP_READ) || (sq.cmd == fic_pkg::EP_BLK_RD))
					nx.op = fic_pkg::FL_READ;
				else if ((sq.cmd == fic_pkg::EP_WRITE) || (sq.cmd == fic_pkg::EP_BLK_WR))
					nx.op = fic_pkg::FL_WRITE;
				else if (sq.cmd == fic_pkg::EP_PAGE)
					nx.op = fic_pkg::FL_PAGE;
				else
					nx.op = fic_pkg::FL_MASS;
				if (nx.left == 8'h00)
					nx.done = 1'h1;
				else if (sq.cmd == fic_pkg::EP_BLK_WR)
					nx.state = fic_pkg::SQ_LOAD;
				else
				begin
					nx.fl_req = 1'h1;
					nx.state = fic_pkg::SQ_WAIT;
				end
			end
		end
		fic_pkg::SQ_LOAD:
		begin
			nx.fl_wdata = ram_rdata;
			nx.fl_req = 1'h1;
			nx.state = fic_pkg::SQ_WAIT;
		end
		fic_pkg::SQ_WAIT:
		begin
			if (fl_ack)
			begin
				nx.fl_req = 1'h0;
				nx.acks = st.acks + 8'h01;
				nx.left = st.left - 8'h01;
				if (st.op == fic_pkg::FL_READ)
				begin
					nx.rdata = fl_rdata;
					nx.ram_we = st.blk;
					nx.ram_wdata = fl_rdata;
				end
				if (st.left == 8'h01)
				begin
					nx.done = 1'h1;
					nx.state = fic_pkg::SQ_IDLE;
				end
				else
					nx.state = fic_pkg::SQ_STEP;
			end
		end
		default:
		begin
			// Step after the RAM write so it lands on the old address
			nx.fl_addr = st.fl_addr + 16'h0001;
			nx.ram_addr = st.ram_addr + 8'h01;
			if (st.op == fic_pkg::FL_WRITE)
				nx.state = fic_pkg::SQ_LOAD;
			else
			begin
				nx.fl_req = 1'h1;
				nx.state = fic_pkg::SQ_WAIT;
			end
		end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			st <= '0;
		else
			st <= nx;
	end

	assign fl_req = st.fl_req;
	assign fl_op = st.op;
	assign fl_addr = st.fl_addr;
	assign fl_wdata = st.fl_wdata;
	assign ram_addr = st.ram_addr;
	assign ram_we = st.ram_we;
	assign ram_wdata = st.ram_wdata;
	assign sq.done = st.done;
	assign sq.rdata = st.rdata;

	blk_count_a: assert property (@(posedge mclk) disable iff (rst) // R6
		(st.done && st.blk) |-> (st.acks == st.cnt_lat))
		else $error("block op byte count mismatch");
	start_addr_a: assert property (@(posedge mclk) disable iff (rst) // R3
		(st.state == fic_pkg::SQ_IDLE && sq.start) |=> (st.fl_addr == $past(sq.addr)))
		else $error("flash address not taken from address registers");
endmodule

// >>> fic_top.sv
// Purpose: Key-gated entry into boot-ROM ISP operations on the on-chip flash
// Assumes: Core signals are synchronous to mclk; irq_src bits are event pulses
// Notes: Registers sit on AXI4-Lite at byte address four times the index
`timescale 1ns/100ps
// Contract
// R1: A call counts as ISP entry only within 6 instruction cycles of the unlock write.
// R2: Software writes the fixed unlock value before the call.
// R3: Flash address is high byte and low byte in two adjacent registers.
// R4: Software loads the write-data register before a single-byte write.
// R5: Single-byte read leaves the fetched byte in the read-data register.
// R6: Block read and write take their length from the byte-count register.
// R7: Software loads write timing before any flash write or erase.
// R8: Software holds the mass-erase confirmation in the accumulator.
// R9: ISP blocks interrupt servicing and leaves the global enable alone.
// R10: Interrupts held during ISP are serviced after return when globally enabled.
// R11: A second request from an already pending source during ISP is dropped.
// R12: An interrupt serviced between unlock and call voids the unlock.
// R13: Software should disable interrupts before writing the unlock value.
// R14: Serial mode checks the security bit before each command.
// R15: Secured serial mode accepts only mass erase, timing write, option read.
// R16: User entry points do no security check.
// R17: ISP keeps servicing the watchdog inside its upper window.
// R18: Return services the watchdog and opens the lower window; software follows.
// R19: Block writes must not cross a half-page or page boundary.
// R20: A location must be erased between two writes to it.
// R21: Mass-erase confirmation code is 0x55.
// R22: Block write count is 0 to 16 and stays inside 64 bytes.
// R23: Exit command ends the session by resetting the device.
// R24: A call without a live unlock is ignored and touches no flash.
module fic_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic call_valid,
	input wire logic [7:0] call_entry,
	input wire logic [7:0] call_acc,
	input wire logic [7:0] call_xptr,
	input wire logic irq_taken,
	input wire logic global_irq_enable,
	input wire logic [7:0] irq_src,
	output logic [7:0] irq_pend,
	output logic irq_block,
	output logic isp_busy,
	output logic call_done,
	input wire logic ser_valid,
	input wire logic [7:0] ser_cmd,
	input wire logic [7:0] ser_data,
	input wire logic security_bit,
	input wire logic [7:0] option_value,
	output logic ser_ack,
	output logic ser_refused,
	output logic [7:0] ser_rdata,
	output logic wdog_service,
	output logic wdog_lower_en,
	output logic reset_req,
	output logic fl_req,
	output logic [1:0] fl_op,
	output logic [15:0] fl_addr,
	output logic [7:0] fl_wdata,
	output logic [7:0] fl_timing,
	input wire logic fl_ack,
	input wire logic [7:0] fl_rdata,
	output logic [7:0] ram_addr,
	output logic ram_we,
	output logic [7:0] ram_wdata,
	input wire logic [7:0] ram_rdata
);
	fic_pkg::fic_top_type st;
	fic_pkg::fic_top_type nx;
	logic key_live;
	logic [7:0] status;
	fic_sq_if sq ();

	// ************************************************************
	// Sequencer
	// ************************************************************
	fic_seq u_seq (
		.mclk(mclk),
		.rst(rst),
		.sq(sq.seq),
		.fl_req(fl_req),
		.fl_op(fl_op),
		.fl_addr(fl_addr),
		.fl_wdata(fl_wdata),
		.fl_ack(fl_ack),
		.fl_rdata(fl_rdata),
		.ram_addr(ram_addr),
		.ram_we(ram_we),
		.ram_wdata(ram_wdata),
		.ram_rdata(ram_rdata)
	);
	assign sq.start = st.seq_start;
	assign sq.cmd = st.cmd;
	assign sq.addr = {st.addr_hi, st.addr_lo}; // R3
	assign sq.wdata = st.wr_data; // R4
	assign sq.count = st.count; // R6
	assign sq.xptr = st.xptr;

	// An interrupt taken this cycle voids the key before the call sees it
	assign key_live = st.key_ok && !irq_taken; // R12
	assign status = {security_bit, global_irq_enable, st.f_masskey, st.f_refused, st.f_ignored,
		st.key_ok, (st.state == fic_pkg::FIC_SER_IDLE) || (st.state == fic_pkg::FIC_SER_RUN),
		st.active};

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		nx = st;
		nx.icyc = 1'h0;
		nx.seq_start = 1'h0;
		nx.wdog_service = 1'h0;
		nx.wdog_lower = 1'h0;
		nx.call_done = 1'h0;
		nx.reset_req = 1'h0;
		nx.ser_ack = 1'h0;
		nx.ser_refused = 1'h0;
		if (st.div == fic_pkg::ICYC_LAST)
		begin
			nx.div = 4'h0;
			nx.icyc = 1'h1;
		end
		else
			nx.div = st.div + 4'h1;
		if (st.icyc && st.key_ok)
		begin
			if (st.key_cnt == 3'h0)
				nx.key_ok = 1'h0; // R1
			else
				nx.key_cnt = st.key_cnt - 3'h1;
		end
		if (st.icyc && (st.key_age != fic_pkg::KEY_AGE_MAX))
			nx.key_age = st.key_age + 4'h1;
		// Bus write: address and data are taken in either order
		if (s_axi_awvalid && st.awready)
		begin
			nx.aw_got = 1'h1;
			nx.awidx = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && st.wready)
		begin
			nx.w_got = 1'h1;
			nx.wbyte = s_axi_wdata[7:0];
			nx.wlane = s_axi_wstrb[0];
		end
		if (st.aw_got && st.w_got && !st.bvalid)
		begin
			nx.aw_got = 1'h0;
			nx.w_got = 1'h0;
			nx.bvalid = 1'h1;
			nx.bresp = fic_pkg::RESP_OKAY;
			if (fic_pkg::fic_hit(st.awidx, fic_pkg::IDX_ADDR_LO))
			begin
				if (st.wlane)
					nx.addr_lo = st.wbyte;
			end
			else if (fic_pkg::fic_hit(st.awidx, fic_pkg::IDX_ADDR_HI))
			begin
				if (st.wlane)
					nx.addr_hi = st.wbyte;
			end
			else if (fic_pkg::fic_hit(st.awidx, fic_pkg::IDX_RD_DATA))
			begin
				if (st.wlane)
					nx.rd_data = st.wbyte;
			end
			else if (fic_pkg::fic_hit(st.awidx, fic_pkg::IDX_WR_DATA))
			begin
				if (st.wlane)
					nx.wr_data = st.wbyte;
			end
			else if (fic_pkg::fic_hit(st.awidx, fic_pkg::IDX_TIMING))
			begin
				if (st.wlane)
					nx.timing = st.wbyte; // R7
			end
			else if (fic_pkg::fic_hit(st.awidx, fic_pkg::IDX_UNLOCK))
			begin
				if (st.wlane)
				begin
					nx.key = st.wbyte;
					nx.key_ok = (st.wbyte == fic_pkg::KEY_VALUE); // R2
					nx.key_cnt = fic_pkg::KEY_WINDOW; // R1
					nx.key_age = 4'h0;
				end
			end
			else if (fic_pkg::fic_hit(st.awidx, fic_pkg::IDX_COUNT))
			begin
				if (st.wlane)
					nx.count = st.wbyte;
			end
			else if (fic_pkg::fic_hit(st.awidx, fic_pkg::IDX_STATUS))
			begin
				// Clears come first so a flag set below in the same cycle survives
				if (st.wlane && st.wbyte[fic_pkg::SB_IGNORED])
					nx.f_ignored = 1'h0;
				if (st.wlane && st.wbyte[fic_pkg::SB_REFUSED])
					nx.f_refused = 1'h0;
				if (st.wlane && st.wbyte[fic_pkg::SB_MASSKEY])
					nx.f_masskey = 1'h0;
			end
			else
				nx.bresp = fic_pkg::RESP_SLVERR;
		end
		if (st.bvalid && s_axi_bready)
			nx.bvalid = 1'h0;
		if (s_axi_arvalid && st.arready)
		begin
			nx.rvalid = 1'h1;
			nx.rresp = fic_pkg::RESP_OKAY;
			if (fic_pkg::fic_hit(s_axi_araddr[11:2], fic_pkg::IDX_ADDR_LO))
				nx.rdata = st.addr_lo;
			else if (fic_pkg::fic_hit(s_axi_araddr[11:2], fic_pkg::IDX_ADDR_HI))
				nx.rdata = st.addr_hi;
			else if (fic_pkg::fic_hit(s_axi_araddr[11:2], fic_pkg::IDX_RD_DATA))
				nx.rdata = st.rd_data;
			else if (fic_pkg::fic_hit(s_axi_araddr[11:2], fic_pkg::IDX_WR_DATA))
				nx.rdata = st.wr_data;
			else if (fic_pkg::fic_hit(s_axi_araddr[11:2], fic_pkg::IDX_TIMING))
				nx.rdata = st.timing;
			else if (fic_pkg::fic_hit(s_axi_araddr[11:2], fic_pkg::IDX_UNLOCK))
				nx.rdata = st.key;
			else if (fic_pkg::fic_hit(s_axi_araddr[11:2], fic_pkg::IDX_COUNT))
				nx.rdata = st.count;
			else if (fic_pkg::fic_hit(s_axi_araddr[11:2], fic_pkg::IDX_STATUS))
				nx.rdata = status;
			else
			begin
				nx.rdata = 8'h00;
				nx.rresp = fic_pkg::RESP_SLVERR;
			end
		end
		if (st.rvalid && s_axi_rready)
			nx.rvalid = 1'h0;
		if (irq_taken)
			nx.key_ok = 1'h0; // R12
		// ************************************************************
		// ISP session control
		// ************************************************************
		case (st.state)
		fic_pkg::FIC_IDLE:
		begin
			if (call_valid && key_live)
			begin
				// User entry points run every command regardless of security
				nx.key_ok = 1'h0; // R16
				nx.xptr = call_xptr;
				nx.cmd = call_entry;
				if (call_entry == fic_pkg::EP_EXIT)
					nx.reset_req = 1'h1; // R23
				else if (call_entry == fic_pkg::EP_SERIAL)
				begin
					nx.state = fic_pkg::FIC_SER_IDLE;
					nx.active = 1'h1;
				end
				else if ((call_entry == fic_pkg::EP_MASS) && (call_acc != fic_pkg::MASS_KEY))
				begin
					nx.f_masskey = 1'h1; // R8 R21
					nx.call_done = 1'h1;
				end
				else if (fic_pkg::fic_is_op(call_entry))
				begin
					nx.seq_start = 1'h1;
					nx.state = fic_pkg::FIC_RUN;
					nx.active = 1'h1;
				end
				else
					nx.call_done = 1'h1;
			end
			else if (call_valid)
				nx.f_ignored = 1'h1; // R24
		end
		fic_pkg::FIC_RUN:
		begin
			if (sq.done)
			begin
				nx.state = fic_pkg::FIC_IDLE;
				nx.active = 1'h0;
				nx.call_done = 1'h1;
				if (st.cmd == fic_pkg::EP_READ)
					nx.rd_data = sq.rdata; // R5
			end
		end
		fic_pkg::FIC_SER_IDLE:
		begin
			if (ser_valid)
			begin
				nx.cmd = ser_cmd;
				if (security_bit && !fic_pkg::fic_sec_ok(ser_cmd)) // R14 R15
				begin
					nx.ser_refused = 1'h1;
					nx.ser_ack = 1'h1;
					nx.f_refused = 1'h1;
				end
				else if (ser_cmd == fic_pkg::SCMD_WR_TIMING)
				begin
					nx.timing = ser_data;
					nx.ser_ack = 1'h1;
				end
				else if (ser_cmd == fic_pkg::SCMD_RD_OPTION)
				begin
					nx.ser_rdata = option_value;
					nx.ser_ack = 1'h1;
				end
				else if (ser_cmd == fic_pkg::EP_EXIT)
				begin
					nx.reset_req = 1'h1; // R23
					nx.state = fic_pkg::FIC_IDLE;
					nx.active = 1'h0;
				end
				else if (fic_pkg::fic_is_op(ser_cmd))
				begin
					nx.seq_start = 1'h1;
					nx.state = fic_pkg::FIC_SER_RUN;
				end
				else
					nx.ser_ack = 1'h1;
			end
		end
		default:
		begin
			if (sq.done)
			begin
				nx.state = fic_pkg::FIC_SER_IDLE;
				nx.ser_ack = 1'h1;
				nx.ser_rdata = sq.rdata;
				if (st.cmd == fic_pkg::EP_READ)
					nx.rd_data = sq.rdata; // R5
			end
		end
		endcase
		// Watchdog kept alive through long erases
		if (!st.active)
			nx.wd_cnt = 10'h000;
		else if (st.icyc && (st.wd_cnt == fic_pkg::WD_SVC_LAST))
		begin
			nx.wd_cnt = 10'h000;
			nx.wdog_service = 1'h1; // R17
		end
		else if (st.icyc)
			nx.wd_cnt = st.wd_cnt + 10'h001;
		if (nx.call_done)
		begin
			nx.wdog_service = 1'h1; // R18
			nx.wdog_lower = 1'h1; // R18
		end
		// A bit per source: a repeat while held merges into the one pending
		if (st.active)
		begin
			nx.irq_pend = 8'h00; // R9
			nx.irq_lat = st.irq_lat | irq_src; // R11
		end
		else
		begin
			nx.irq_pend = st.irq_lat | irq_src; // R10
			nx.irq_lat = 8'h00;
		end
		nx.irq_block = nx.active; // R9
		nx.awready = !nx.aw_got && !nx.bvalid;
		nx.wready = !nx.w_got && !nx.bvalid;
		nx.arready = !nx.rvalid;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			st <= '0;
		else
			st <= nx;
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bresp = st.bresp;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_arready = st.arready;
	assign s_axi_rdata = {24'h000000, st.rdata};
	assign s_axi_rresp = st.rresp;
	assign s_axi_rvalid = st.rvalid;
	assign irq_pend = st.irq_pend;
	assign irq_block = st.irq_block;
	assign isp_busy = st.active;
	assign call_done = st.call_done;
	assign ser_ack = st.ser_ack;
	assign ser_refused = st.ser_refused;
	assign ser_rdata = st.ser_rdata;
	assign wdog_service = st.wdog_service;
	assign wdog_lower_en = st.wdog_lower;
	assign reset_req = st.reset_req;
	assign fl_timing = st.timing; // R7

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	key_window_a: assert property (st.key_ok |-> (st.key_age <= {1'h0, fic_pkg::KEY_WINDOW})) // R1
		else $error("unlock alive past its window");
	no_key_a: assert property ((st.state == fic_pkg::FIC_IDLE && call_valid && !st.key_ok) // R24
		|=> (!st.active && !st.seq_start)) else $error("call without unlock started ISP");
	irq_hold_a: assert property (st.active |=> (st.irq_pend == 8'h00)) // R9
		else $error("interrupt passed during ISP");
	irq_release_a: assert property ((!st.active && st.irq_lat != 8'h00) // R10
		|=> ((st.irq_pend & $past(st.irq_lat)) == $past(st.irq_lat)))
		else $error("held interrupt not released");
	irq_void_a: assert property (irq_taken |=> !st.key_ok) // R12
		else $error("unlock survived interrupt");
	ser_secure_a: assert property ((st.state == fic_pkg::FIC_SER_IDLE && ser_valid // R15
		&& security_bit && !fic_pkg::fic_sec_ok(ser_cmd)) |=> (st.ser_refused && !st.seq_start))
		else $error("secured serial command not refused");
	user_nosec_a: assert property ((st.state == fic_pkg::FIC_IDLE && call_valid && key_live // R16
		&& security_bit && call_entry == fic_pkg::EP_BLK_RD) |=> (st.state == fic_pkg::FIC_RUN))
		else $error("user call blocked by security");
	wd_run_a: assert property ((st.active && st.icyc // R17
		&& st.wd_cnt == fic_pkg::WD_SVC_LAST) |=> st.wdog_service)
		else $error("watchdog not serviced in ISP");
	wd_return_a: assert property ($fell(st.active) && (st.state == fic_pkg::FIC_IDLE) // R18
		&& !st.reset_req |-> (st.wdog_service && st.wdog_lower))
		else $error("return without watchdog service");
	exit_reset_a: assert property ((st.state == fic_pkg::FIC_SER_IDLE && ser_valid // R23
		&& !security_bit && ser_cmd == fic_pkg::EP_EXIT) |=> (st.reset_req && !st.active))
		else $error("exit did not request reset");
	read_byte_a: assert property ((st.state == fic_pkg::FIC_RUN && sq.done // R5
		&& st.cmd == fic_pkg::EP_READ) |=> (st.rd_data == $past(sq.rdata)))
		else $error("read data not stored");
endmodule

// >>> fic_flash_model.sv
// Purpose: Behavioural flash array and RAM seen by the sequencer
// Assumes: One acknowledge per request
// Notes: Latency alternates prompt and slow; released data toggles
`timescale 1ns/100ps
module fic_flash_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic fl_req,
	input wire logic [15:0] fl_addr,
	output logic fl_ack,
	output logic [7:0] fl_rdata,
	input wire logic [7:0] ram_addr,
	output logic [7:0] ram_rdata
);
	int cnt = 0;
	int dly = 0;
	assign ram_rdata = ram_addr ^ 8'h3c;
	always @(posedge mclk)
	begin
		fl_ack <= 1'b0;
		// Stale data is inverted so a late capture cannot pass by luck
		fl_rdata <= rst ? 8'h00 : ~fl_rdata;
		cnt <= 0;
		if (!rst && fl_req && !fl_ack && cnt < dly)
			cnt <= cnt + 1;
		else if (!rst && fl_req && !fl_ack)
		begin
			fl_ack <= 1'b1;
			fl_rdata <= fl_addr[7:0] ^ fl_addr[15:8] ^ 8'h5a;
			dly <= 3 - dly;
		end
	end
endmodule

// >>> tb_flash_isp_entry_control.sv
// Purpose: Self-checking bench for the flash ISP entry control
// Assumes: Bus readies are sampled on the falling edge
// Notes: Serial session runs last
`timescale 1ns/100ps
module tb_flash_isp_entry_control;
	logic mclk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1, call_valid = 0, irq_taken = 0;
	logic global_irq_enable = 1, ser_valid = 0, security_bit = 0, lower_seen = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, fl_op;
	logic [25:0] lfl;
	logic [7:0] call_entry = 0, call_acc = 0, call_xptr = 0, irq_src = 0, ser_cmd = 0;
	logic [7:0] ser_data = 8'h5c, option_value = 8'h96, irq_pend, ser_rdata, fl_wdata, fl_timing;
	logic [7:0] fl_rdata, ram_addr, ram_wdata, ram_rdata;
	logic irq_block, isp_busy, call_done, ser_ack, ser_refused, wdog_service, wdog_lower_en;
	logic reset_req, fl_req, fl_ack, ram_we;
	logic [15:0] fl_addr;
	int err_total = 0, comparisons = 0, wt = 0, acks = 0, wes = 0, wds = 0, ips = 0;
	always #2.5 mclk = ~mclk;
	fic_top uut (.*);
	fic_flash_model flash (.mclk, .rst, .fl_req, .fl_addr, .fl_ack, .fl_rdata, .ram_addr,
		.ram_rdata);
	always @(posedge mclk)
	begin
		acks <= acks + int'(fl_ack);
		wes <= wes + int'(ram_we);
		lfl <= fl_ack ? {fl_op, fl_addr, fl_wdata} : lfl;
		wds <= wds + int'(wdog_service & isp_busy);
		ips <= ips + int'(irq_pend[0]) + int'(irq_pend[2]);
		lower_seen <= call_done ? wdog_lower_en : lower_seen;
	end
	task summarize;
		err_total += int'(wt > 300);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task step;
		@(negedge mclk);
		if (++wt > 300)
			summarize;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		wt = 0;
		do step; while ((s_axi_awready & s_axi_wready) !== 1'b1);
		@(posedge mclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do step; while (s_axi_bvalid !== 1'b1);
		@(posedge mclk);
	endtask
	task rdr(input logic [7:0] idx);
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		wt = 0;
		do step; while (s_axi_arready !== 1'b1);
		@(posedge mclk);
		s_axi_arvalid <= 1'b0;
		do step; while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		@(posedge mclk);
	endtask
	task call(input logic [7:0] ep, input logic [7:0] acc, input logic wait_done);
		call_entry <= ep;
		call_acc <= acc;
		call_valid <= 1'b1;
		@(posedge mclk);
		call_valid <= 1'b0;
		wt = 0;
		if (wait_done)
			do step; while (call_done !== 1'b1);
		repeat (6) @(posedge mclk);
	endtask
	task kcall(input logic [7:0] ep);
		wr(fic_pkg::IDX_UNLOCK, fic_pkg::KEY_VALUE);
		call(ep, 8'h00, ep != fic_pkg::EP_SERIAL);
	endtask
	task ser(input logic [7:0] c, input logic [11:0] e);
		ser_cmd <= c;
		ser_valid <= 1'b1;
		@(posedge mclk);
		ser_valid <= 1'b0;
		@(negedge mclk);
		chk(32'({irq_block, reset_req, ser_ack, ser_refused, ser_rdata}), 32'(e));
		@(posedge mclk);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task s_read;
		wr(fic_pkg::IDX_ADDR_HI, 8'h12);
		wr(fic_pkg::IDX_ADDR_LO, 8'h34);
		kcall(fic_pkg::EP_READ);
		chk({31'h0, lower_seen}, 32'h1);
		rdr(fic_pkg::IDX_RD_DATA);
		chk(rd, {24'h0, 8'h34 ^ 8'h12 ^ 8'h5a});
	endtask
	// Mode 0 no key, 1 key too old, 2 interrupt between key and call
	task s_ignore(input int mode);
		int a0;
		a0 = acks;
		if (mode > 0)
			wr(fic_pkg::IDX_UNLOCK, fic_pkg::KEY_VALUE);
		irq_taken <= (mode == 2);
		repeat (mode == 1 ? 80 : 1) @(posedge mclk);
		irq_taken <= 1'b0;
		call(fic_pkg::EP_WRITE, 8'h00, 1'b0);
		chk(32'(acks), 32'(a0));
		rdr(fic_pkg::IDX_STATUS);
		chk(rd & 32'h8, 32'h8);
		wr(fic_pkg::IDX_STATUS, 8'h08);
	endtask
	task s_mass;
		kcall(fic_pkg::EP_MASS);
		rdr(fic_pkg::IDX_STATUS);
		chk(rd & 32'h20, 32'h20);
		wr(fic_pkg::IDX_UNLOCK, fic_pkg::KEY_VALUE);
		call(fic_pkg::EP_MASS, fic_pkg::MASS_KEY, 1'b1);
		chk({30'h0, lfl[25:24]}, 32'h3);
	endtask
	task s_blk;
		int a0;
		a0 = wes;
		security_bit <= 1'b1;
		wr(fic_pkg::IDX_COUNT, 8'h03);
		wr(fic_pkg::IDX_UNLOCK, fic_pkg::KEY_VALUE);
		repeat (45) @(posedge mclk);
		call(fic_pkg::EP_BLK_RD, 8'h00, 1'b1);
		chk(32'(wes - a0), 32'h3);
	endtask
	task s_wr;
		wr(fic_pkg::IDX_TIMING, 8'h2d);
		kcall(fic_pkg::EP_BLK_WR);
		chk(32'(lfl), 32'h112363e);
		kcall(fic_pkg::EP_PAGE);
		chk(32'(lfl[25:8]), 32'h21234);
		wr(fic_pkg::IDX_WR_DATA, 8'h6b);
		kcall(fic_pkg::EP_WRITE);
		chk(32'(lfl), 32'h112346b);
		chk(32'(fl_timing), 32'h2d);
	endtask
	task s_ser;
		kcall(fic_pkg::EP_SERIAL);
		irq_src <= 8'h05;
		@(posedge mclk);
		irq_src <= 8'h04;
		@(posedge mclk);
		irq_src <= 8'h00;
		ser(fic_pkg::EP_READ, 12'hb00);
		ser(fic_pkg::SCMD_RD_OPTION, 12'ha96);
		ser(fic_pkg::SCMD_WR_TIMING, 12'ha96);
		repeat (5020) @(posedge mclk);
		chk(32'(wds), 32'h1);
		security_bit <= 1'b0;
		ser(fic_pkg::EP_EXIT, 12'h496);
		repeat (2) @(posedge mclk);
		chk(32'(ips), 32'h2);
	endtask
	initial
	begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		s_read;
		for (int m = 0; m < 3; m++)
			s_ignore(m);
		s_mass;
		s_blk;
		s_wr;
		s_ser;
		summarize;
	end
endmodule
